// *** mpc_pwm.sv ***
// Three-phase PWM generator with chopper, prescaler and repetition-paced updates
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module mpc_pwm
   import mpc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Analog comparator results
   input wire logic bemf_comparator_in,
   input wire logic cmp_amplifier_output,
   input wire logic cmp_current_input_direct,
   output logic current_input_select,
   // Inverter drive and update request
   output logic [2:0] pwm_high_o,
   output logic [2:0] pwm_low_o,
   output logic update_irq_o
);
   // ==========================================================================
   // Registers
   logic [2:0] chop_freq_sel_q, chop_freq_sel_d;
   logic [1:0] chop_mode_q, chop_mode_d;
   logic csel_q, csel_d;
   logic compare_layout_sel_q, compare_layout_sel_d;
   logic [2:0] force_pre_q, force_pre_d;
   logic counter_align_sel_q, counter_align_sel_d;
   logic [2:0] counter_prescale_q, counter_prescale_d;
   logic [7:0] repeat_value_q, repeat_value_d;
   logic [7:0] rep_act_q, rep_act_d;
   logic [7:0] rep_cnt_q, rep_cnt_d;
   logic [7:0] cmp_pre_q [3], cmp_pre_d [3];
   logic [7:0] cmp_act_q [3], cmp_act_d [3];
   logic [2:0] force_act_q, force_act_d;
   logic cke_q, cke_d, uie_q, uie_d, cke_dly_q;
   logic [2:0] psc_q, psc_d;
   logic [7:0] cnt_q, cnt_d;
   mpc_dir_e dir_q, dir_d;
   logic [7:0] chop_cnt_q, chop_cnt_d;
   logic chop_q, chop_d;
   logic ack_q, irq_q;
   logic [31:0] dat_q, dat_d;
   logic [2:0] pwm_hi_q, pwm_lo_q;

   // ==========================================================================
   // Bus decode
   wire bus_req = cyc_i & stb_i & ~ack_q;
   wire wr_lane = bus_req & we_i & sel_i[0];
   wire wr_ccc = wr_lane & (adr_i == MPC_ADR_CCC);
   wire wr_pwmc = wr_lane & (adr_i == MPC_ADR_PWMC);
   wire wr_rep = wr_lane & (adr_i == MPC_ADR_REP);
   wire wr_ctrl = wr_lane & (adr_i == MPC_ADR_CTRL);
   wire [2:0] wr_cmp = {wr_lane & (adr_i == MPC_ADR_CMPW),
                        wr_lane & (adr_i == MPC_ADR_CMPV),
                        wr_lane & (adr_i == MPC_ADR_CMPU)};
   wire [7:0] wb = dat_i[7:0];
   // Register carries U in its top force bit; phase index 0 is U everywhere else
   wire [2:0] wr_force = {wb[MPC_FORCE_LSB], wb[MPC_FORCE_LSB + 1], wb[MPC_FORCE_LSB + 2]};

   // Current comparator source select and its result
   wire cur_state = csel_q ? cmp_current_input_direct : cmp_amplifier_output;
   assign current_input_select = csel_q;

   // ==========================================================================
   // Counter timing: prescaler tick, boundaries, update event
   wire tick = cke_q & (psc_q == counter_prescale_q);
   wire edge_end = tick & ~counter_align_sel_q & (cnt_q == MPC_CNT_TOP);
   wire ctr_turn_up = tick & counter_align_sel_q & (dir_q == MPC_UP) & (cnt_q == MPC_CNT_TOP);
   wire ctr_turn_dn = tick & counter_align_sel_q & (dir_q == MPC_DOWN) & (cnt_q == 8'h00);
   // Center mode counts both turns, so one repetition step is half a period
   wire boundary = edge_end | ctr_turn_up | ctr_turn_dn;
   wire cke_rise = cke_q & ~cke_dly_q;
   wire upd = cke_rise | (boundary & (rep_cnt_q == 8'h00));

   // Prescaler and PWM counter
   always_comb begin
      psc_d = psc_q;
      cnt_d = cnt_q;
      dir_d = dir_q;
      if (!cke_q) begin
         psc_d = 3'h0;
      end else if (tick) begin
         psc_d = 3'h0;
      end else begin
         psc_d = psc_q + 3'h1;
      end
      if (tick) begin
         case (dir_q)
            MPC_UP: begin
               if (counter_align_sel_q && cnt_q == MPC_CNT_TOP) begin
                  dir_d = MPC_DOWN;
                  cnt_d = cnt_q - 8'h01;
               end else begin
                  cnt_d = cnt_q + 8'h01;
               end
            end
            MPC_DOWN: begin
               // Edge mode always climbs, even if it was left while counting down
               if (cnt_q == 8'h00 || !counter_align_sel_q) begin
                  dir_d = MPC_UP;
                  cnt_d = cnt_q + 8'h01;
               end else begin
                  cnt_d = cnt_q - 8'h01;
               end
            end
            default: dir_d = MPC_UP;
         endcase
      end
   end

   // ==========================================================================
   // Repetition counter: preload written by software, active loaded on update
   always_comb begin
      repeat_value_d = wr_rep ? wb : repeat_value_q;
      rep_act_d = rep_act_q;
      rep_cnt_d = rep_cnt_q;
      if (upd) begin
         rep_act_d = repeat_value_q;
         rep_cnt_d = repeat_value_q;
      end else if (boundary) begin
         rep_cnt_d = rep_cnt_q - 8'h01;
      end
   end

   // Compare preloads and force bits move to active on update
   always_comb begin
      force_act_d = upd ? force_pre_q : force_act_q;
      force_pre_d = upd ? 3'h0 : force_pre_q;
      // A software write in the update cycle is kept for the next update
      if (wr_pwmc) begin
         force_pre_d = wr_force;
      end
      for (int i = 0; i < 3; i++) begin
         cmp_pre_d[i] = wr_cmp[i] ? wb : cmp_pre_q[i];
         cmp_act_d[i] = upd ? cmp_pre_q[i] : cmp_act_q[i];
      end
   end

   // Plain control fields
   always_comb begin
      chop_freq_sel_d = wr_ccc ? wb[MPC_FREQ_LSB +: 3] : chop_freq_sel_q;
      chop_mode_d = wr_ccc ? wb[MPC_CHOP_LSB +: 2] : chop_mode_q;
      csel_d = wr_ccc ? wb[MPC_CSEL_BIT] : csel_q;
      compare_layout_sel_d = wr_pwmc ? wb[MPC_LAYOUT_BIT] : compare_layout_sel_q;
      counter_align_sel_d = wr_pwmc ? wb[MPC_ALIGN_BIT] : counter_align_sel_q;
      counter_prescale_d = wr_pwmc ? wb[MPC_PSC_LSB +: 3] : counter_prescale_q;
      cke_d = wr_ctrl ? wb[MPC_CKE_BIT] : cke_q;
      uie_d = wr_ctrl ? wb[MPC_UIE_BIT] : uie_q;
   end

   // ==========================================================================
   // Chopper: toggles every half period so duty stays 50% at any frequency
   wire [7:0] chop_half = mpc_chop_half(chop_freq_sel_q);
   always_comb begin
      chop_cnt_d = chop_cnt_q + 8'h01;
      chop_d = chop_q;
      if (chop_cnt_q >= chop_half - 8'h01) begin
         chop_cnt_d = 8'h00;
         chop_d = ~chop_q;
      end
      // Restart on a config write so the running half is timed afresh at the new rate
      if (wr_ccc) begin
         chop_cnt_d = 8'h00;
         chop_d = chop_q;
      end
   end

   // Phase duty: compare layout 0 uses bit 7 as a full-duty extension bit; layout 1 compares the whole byte
   logic [2:0] phase_on;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (force_act_q[i]) begin
            phase_on[i] = 1'b1;
         end else if (compare_layout_sel_q) begin
            phase_on[i] = cnt_q < cmp_act_q[i];
         end else begin
            phase_on[i] = cmp_act_q[i][MPC_EXT_BIT] | (cnt_q < {cmp_act_q[i][6:0], 1'b0});
         end
      end
   end
   wire hi_gate = ~chop_mode_q[1] | chop_q;
   wire lo_gate = ~chop_mode_q[0] | chop_q;
   wire [2:0] pwm_hi_d = (cke_q ? phase_on : 3'h0) & {3{hi_gate}};
   wire [2:0] pwm_lo_d = (cke_q ? ~phase_on : 3'h0) & {3{lo_gate}};

   // ==========================================================================
   // Read mux: repetition and compare registers return their active copy; force bits return their preload
   always_comb begin
      dat_d = 32'h0000_0000;
      case (adr_i)
         MPC_ADR_CCC: begin
            dat_d[7:0] = {bemf_comparator_in, cur_state, csel_q, chop_mode_q,
                          chop_freq_sel_q};
         end
         MPC_ADR_PWMC: begin
            dat_d[7:0] = {compare_layout_sel_q, force_pre_q[0], force_pre_q[1], force_pre_q[2],
                          counter_align_sel_q,
                          counter_prescale_q};
         end
         MPC_ADR_REP: dat_d[7:0] = rep_act_q;
         MPC_ADR_CMPU: dat_d[7:0] = cmp_act_q[0];
         MPC_ADR_CMPV: dat_d[7:0] = cmp_act_q[1];
         MPC_ADR_CMPW: dat_d[7:0] = cmp_act_q[2];
         MPC_ADR_CTRL: dat_d[7:0] = {6'h00, uie_q, cke_q};
         default: dat_d = 32'h0000_0000;
      endcase
   end

   // ==========================================================================
   // Flip-flops
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chop_freq_sel_q <= 3'h0;
         chop_mode_q <= 2'h0;
         csel_q <= 1'b0;
         compare_layout_sel_q <= 1'b0;
         force_pre_q <= 3'h0;
         counter_align_sel_q <= 1'b0;
         counter_prescale_q <= 3'h0;
         cke_q <= 1'b0;
         uie_q <= 1'b0;
         cke_dly_q <= 1'b0;
      end else begin
         chop_freq_sel_q <= chop_freq_sel_d;
         chop_mode_q <= chop_mode_d;
         csel_q <= csel_d;
         compare_layout_sel_q <= compare_layout_sel_d;
         force_pre_q <= force_pre_d;
         counter_align_sel_q <= counter_align_sel_d;
         counter_prescale_q <= counter_prescale_d;
         cke_q <= cke_d;
         uie_q <= uie_d;
         cke_dly_q <= cke_q;
      end
   end

   // Counting and update state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         repeat_value_q <= MPC_RST_REP;
         rep_act_q <= MPC_RST_REP;
         rep_cnt_q <= MPC_RST_REP;
         force_act_q <= 3'h0;
         psc_q <= 3'h0;
         cnt_q <= 8'h00;
         dir_q <= MPC_UP;
         chop_cnt_q <= 8'h00;
         chop_q <= 1'b0;
         cmp_pre_q <= '{3{MPC_RST_BYTE}};
         cmp_act_q <= '{3{MPC_RST_BYTE}};
      end else begin
         repeat_value_q <= repeat_value_d;
         rep_act_q <= rep_act_d;
         rep_cnt_q <= rep_cnt_d;
         force_act_q <= force_act_d;
         psc_q <= psc_d;
         cnt_q <= cnt_d;
         dir_q <= dir_d;
         chop_cnt_q <= chop_cnt_d;
         chop_q <= chop_d;
         cmp_pre_q <= cmp_pre_d;
         cmp_act_q <= cmp_act_d;
      end
   end

   // Bus answer and outputs; ack one cycle after the request, then drops
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         irq_q <= 1'b0;
         pwm_hi_q <= 3'h0;
         pwm_lo_q <= 3'h0;
      end else begin
         ack_q <= bus_req;
         dat_q <= bus_req ? dat_d : dat_q;
         irq_q <= upd & uie_q;
         pwm_hi_q <= pwm_hi_d;
         pwm_lo_q <= pwm_lo_d;
      end
   end
   assign ack_o = ack_q;
   assign dat_o = dat_q;
   assign update_irq_o = irq_q;
   assign pwm_high_o = pwm_hi_q;
   assign pwm_low_o = pwm_lo_q;

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire rd_ccc = bus_req & ~we_i & (adr_i == MPC_ADR_CCC);
   wire rd_rep = bus_req & ~we_i & (adr_i == MPC_ADR_REP);
   wire rd_cmpw = bus_req & ~we_i & (adr_i == MPC_ADR_CMPW);

   a_bemf_status: assert property (rd_ccc |=> dat_o[7] == $past(bemf_comparator_in))
      else $error("back-EMF status bit wrong");
   a_cur_status: assert property (rd_ccc |=> dat_o[6] == $past(cur_state))
      else $error("current comparator status bit wrong");
   a_cur_source: assert property (rd_ccc && csel_q |=> dat_o[6] == $past(cmp_current_input_direct))
      else $error("current source select ignored");
   a_chop_off_hi: assert property (chop_mode_q == 2'b00 && cke_q
      |=> pwm_high_o == $past(phase_on))
      else $error("high side chopped while chopping off");
   a_chop_low_only: assert property (chop_mode_q == 2'b01 && cke_q |=> pwm_high_o == $past(phase_on))
      else $error("high side chopped in low-only mode");
   a_chop_half: assert property ($changed(chop_q) |-> $past(chop_cnt_q) == $past(chop_half) - 8'h01)
      else $error("chopper half period wrong");
   a_chop_rate: assert property (chop_freq_sel_q == 3'h7 |-> chop_half == 8'h05)
      else $error("2 MHz chopper count wrong");
   a_psc_gap: assert property (tick && counter_prescale_q != 3'h0 && !wr_pwmc
      |=> !tick ##1 $stable(cnt_q))
      else $error("prescaler tick spacing wrong");
   a_force_full: assert property (force_act_q[2] && cke_q && chop_mode_q == 2'b00 |=> pwm_high_o[2])
      else $error("forced phase not at full duty");
   a_force_clear: assert property (upd && !wr_pwmc |=> force_pre_q == 3'h0 && force_act_q == $past(force_pre_q))
      else $error("force bit not moved and cleared");
   a_rep_reload: assert property (upd |=> rep_cnt_q == $past(repeat_value_q) && rep_act_q == $past(repeat_value_q))
      else $error("repetition reload wrong");
   a_irq_gate: assert property (update_irq_o |-> $past(upd) && $past(uie_q))
      else $error("update interrupt without enabled update");
   a_cke_update: assert property ($rose(cke_q) && uie_q |=> update_irq_o && rep_act_q == $past(repeat_value_q))
      else $error("clock enable did not force update");
   a_rep_hold: assert property (wr_rep && cke_q && !upd |=> rep_act_q == $past(rep_act_q))
      else $error("repetition value applied before update");
   a_rep_step: assert property (boundary && !upd |=> rep_cnt_q == $past(rep_cnt_q) - 8'h01)
      else $error("repetition step wrong");
   a_rep_read: assert property (rd_rep |=> dat_o[7:0] == $past(rep_act_q))
      else $error("repetition read not active value");
   a_center_turn: assert property (ctr_turn_up |=> dir_q == MPC_DOWN)
      else $error("center mode failed to turn");
   a_center_bottom: assert property (ctr_turn_dn |=> dir_q == MPC_UP && cnt_q == 8'h01)
      else $error("center mode failed to turn at bottom");
   a_edge_wrap: assert property (edge_end |=> cnt_q == 8'h00)
      else $error("edge mode failed to wrap");

   // Chopper gating on both sides
   a_chop_off_lo: assert property (chop_mode_q == 2'b00 && cke_q
      |=> pwm_low_o == ~$past(phase_on))
      else $error("low side chopped while chopping off");
   a_chop_hi_only: assert property (chop_mode_q == 2'b10 && cke_q
      |=> pwm_low_o == ~$past(phase_on))
      else $error("low side chopped in high-only mode");
   a_chop_gate_hi: assert property (chop_mode_q[1] && !chop_q |=> pwm_high_o == 3'h0)
      else $error("high side not gated by chopper");
   a_chop_gate_lo: assert property (chop_mode_q[0] && !chop_q |=> pwm_low_o == 3'h0)
      else $error("low side not gated by chopper");

   // Compare layout, force hold and compare transfer
   a_layout_ext: assert property (!compare_layout_sel_q && cmp_act_q[2][MPC_EXT_BIT]
      && !force_act_q[2] && cke_q && chop_mode_q == 2'b00 |=> pwm_high_o[2])
      else $error("extension bit did not give full duty");
   a_force_hold: assert property (force_act_q != 3'h0 && !upd
      |=> force_act_q == $past(force_act_q))
      else $error("active force changed between updates");
   a_cmp_transfer: assert property (upd |=> cmp_act_q[2] == $past(cmp_pre_q[2]))
      else $error("compare preload not transferred");
   a_cmp_read: assert property (rd_cmpw |=> dat_o[7:0] == $past(cmp_act_q[2]))
      else $error("compare read not active value");

   // Interrupt pacing
   a_irq_rate: assert property (boundary && rep_cnt_q != 8'h00 && !cke_rise
      |=> !update_irq_o)
      else $error("update interrupt before repetition ran out");
   a_irq_masked: assert property (upd && !uie_q |=> !update_irq_o)
      else $error("update interrupt while disabled");

   c_update: cover property (upd ##1 update_irq_o);
   c_force: cover property (upd && force_pre_q != 3'h0);
   c_center: cover property (ctr_turn_dn);
   c_center_update: cover property (ctr_turn_up && upd);
   c_chop_both: cover property (chop_mode_q == 2'b11 && $changed(chop_q));
endmodule

// *** mpc_pkg.sv ***
// Package with register map, field layout and timing constants of the motor PWM block
// ==========================================================================
package mpc_pkg;
   // ==========================================================================
   // Register byte addresses
   localparam logic [7:0] MPC_ADR_CCC = 8'h00;
   localparam logic [7:0] MPC_ADR_PWMC = 8'h04;
   localparam logic [7:0] MPC_ADR_REP = 8'h08;
   localparam logic [7:0] MPC_ADR_CMPW = 8'h0C;
   localparam logic [7:0] MPC_ADR_CTRL = 8'h10;
   localparam logic [7:0] MPC_ADR_CMPU = 8'h14;
   localparam logic [7:0] MPC_ADR_CMPV = 8'h18;
   // ==========================================================================
   // Field positions
   localparam int MPC_BEMF_BIT = 7;
   localparam int MPC_CUR_BIT = 6;
   localparam int MPC_CSEL_BIT = 5;
   localparam int MPC_CHOP_LSB = 3;
   localparam int MPC_FREQ_LSB = 0;
   localparam int MPC_LAYOUT_BIT = 7;
   localparam int MPC_FORCE_LSB = 4;
   localparam int MPC_ALIGN_BIT = 3;
   localparam int MPC_PSC_LSB = 0;
   localparam int MPC_CKE_BIT = 0;
   localparam int MPC_UIE_BIT = 1;
   localparam int MPC_EXT_BIT = 7;
   // ==========================================================================
   // Reset values and counter top
   localparam logic [7:0] MPC_RST_BYTE = 8'h00;
   localparam logic [7:0] MPC_RST_REP = 8'h00;
   localparam logic [7:0] MPC_CNT_TOP = 8'hFF;
   // ==========================================================================
   // Timing: peripheral clock and chopper half-period in cycles
   localparam int MPC_CLK_HZ = 20_000_000;
   typedef enum logic [1:0] {MPC_UP = 2'b01, MPC_DOWN = 2'b10} mpc_dir_e;
   // Half period rounds down; a whole toggle pair keeps duty at exactly 50%
   function automatic logic [7:0] mpc_chop_half(input logic [2:0] sel);
      int hz;
      case (sel)
         3'h0: hz = 100_000;
         3'h1: hz = 200_000;
         3'h2: hz = 400_000;
         3'h3: hz = 500_000;
         3'h4: hz = 800_000;
         3'h5: hz = 1_000_000;
         3'h6: hz = 1_333_333;
         default: hz = 2_000_000;
      endcase
      return 8'(MPC_CLK_HZ / (2 * hz));
   endfunction
endpackage

// *** mpc_bridge_model.sv ***
// Inverter bridge model that watches the six gate drives of the generator
`timescale 1ns/100ps
module mpc_bridge_model (
   // Clock
   input wire logic ref_clk,
   // Gate drives from the generator
   input wire logic [2:0] gate_high,
   input wire logic [2:0] gate_low,
   // Sticky fault flag read by the bench
   output logic leg_short
);
   // ==========================================================================
   // Shoot-through watch
   // Both switches of one leg on shorts the supply, so a single cycle is fatal
   initial leg_short = 1'b0;
   always @(posedge ref_clk) begin
      if ((gate_high & gate_low) != 3'h0) begin
         leg_short <= 1'b1;  // Latched so a short pulse is not missed
      end
   end
endmodule

// *** mpc_pwm_tb.sv ***
// Self-checking bench for the motor PWM generator
`timescale 1ns/100ps
module mpc_pwm_tb
   import mpc_pkg::*;
;
   // ==========================================================================
   // Stimulus and observed signals
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h00000000;
   logic bemf_in = 1'b0;
   logic amp_in = 1'b0;
   logic dir_in = 1'b0;
   logic [31:0] dat_o;
   logic ack_o;
   logic current_input_select;
   logic [2:0] pwm_high_o;
   logic [2:0] pwm_low_o;
   logic update_irq_o;
   logic leg_short;
   int err_total = 0;
   int check_count = 0;
   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;
   mpc_pwm mpc_pwm_inst (.ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .bemf_comparator_in(bemf_in), .cmp_amplifier_output(amp_in),
      .cmp_current_input_direct(dir_in), .current_input_select(current_input_select),
      .pwm_high_o(pwm_high_o), .pwm_low_o(pwm_low_o), .update_irq_o(update_irq_o));
   mpc_bridge_model mpc_bridge_model_inst (.ref_clk(ref_clk), .gate_high(pwm_high_o),
      .gate_low(pwm_low_o), .leg_short(leg_short));
   // ==========================================================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Classic single cycle; request held until ack is sampled high
   task automatic wb(input logic [7:0] adr, input logic we, input logic [7:0] wd,
                     output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= adr;
      sel_i <= 4'hF;
      dat_i <= {24'h000000, wd};
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (n >= 20) begin
         check("bus ack", 32'h0, 32'h1);
      end
   endtask
   // Cycles from the call to the next update request
   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (update_irq_o !== 1'b1 && n < 3000);
   endtask
   // High-side counts in [0..2], low-side counts in [3..5]
   task automatic measure(input int cyc, output int hc [6]);
      hc = '{default: 0};
      repeat (cyc) begin
         @(posedge ref_clk);
         for (int i = 0; i < 3; i++) begin
            hc[i] += int'(pwm_high_o[i] === 1'b1);
            hc[i + 3] += int'(pwm_low_o[i] === 1'b1);
         end
      end
   endtask
   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         wb(8'(i * 4), 1'b0, 8'h00, r);
         check("reset value", r, MPC_RST_BYTE);
      end
      wb(8'h1C, 1'b1, 8'h5A, r);
      wb(8'h1C, 1'b0, 8'h00, r);
      check("unmapped read", r, 8'h00);
      check("idle drive", {pwm_high_o, pwm_low_o, update_irq_o}, 7'h00);
   endtask
   task automatic t_status();
      logic [7:0] r;
      bemf_in <= 1'b1;
      amp_in <= 1'b1;
      repeat (3) @(posedge ref_clk);
      wb(MPC_ADR_CCC, 1'b0, 8'h00, r);
      check("status amp", r, 8'hC0);
      wb(MPC_ADR_CCC, 1'b1, 8'h3F, r);
      bemf_in <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check("input select", current_input_select, 1'b1);
      wb(MPC_ADR_CCC, 1'b0, 8'h00, r);
      check("status direct", r, 8'h3F);
      dir_in <= 1'b1;
      wb(MPC_ADR_CCC, 1'b1, 8'h00, r);
      repeat (3) @(posedge ref_clk);
      wb(MPC_ADR_CCC, 1'b0, 8'h00, r);
      check("status amp again", r, 8'h40);
   endtask
   task automatic t_pacing();
      int n;
      logic [7:0] r;
      wb(MPC_ADR_REP, 1'b1, 8'h01, r);
      wb(MPC_ADR_CTRL, 1'b1, 8'h03, r);
      wait_irq(n);
      check("enable update", n <= 4, 1'b1);
      wb(MPC_ADR_REP, 1'b0, 8'h00, r);
      check("rep loaded", r, 8'h01);
      wait_irq(n);
      wait_irq(n);
      check("rep period", n, 512);
      wb(MPC_ADR_PWMC, 1'b1, 8'h01, r);
      wait_irq(n);
      wait_irq(n);
      check("prescaled period", n, 1024);
      wb(MPC_ADR_REP, 1'b1, 8'h00, r);
      wb(MPC_ADR_REP, 1'b0, 8'h00, r);
      check("rep held", r, 8'h01);
      wait_irq(n);
      wb(MPC_ADR_REP, 1'b0, 8'h00, r);
      check("rep taken", r, 8'h00);
      wait_irq(n);
      wait_irq(n);
      check("short period", n, 512);
      wb(MPC_ADR_CTRL, 1'b1, 8'h01, r);
      wait_irq(n);
      check("irq masked", n, 3000);
      wb(MPC_ADR_CTRL, 1'b1, 8'h03, r);
   endtask
   task automatic t_duty();
      logic [7:0] pc [3] = '{8'h00, 8'h00, 8'h80};
      logic [7:0] cw [3] = '{8'h80, 8'h20, 8'h20};
      int ex [3] = '{256, 64, 32};
      int n;
      int hc [6];
      logic [7:0] r;
      for (int i = 0; i < 3; i++) begin
         wb(MPC_ADR_PWMC, 1'b1, pc[i], r);
         wb(MPC_ADR_CMPW, 1'b1, cw[i], r);
         wait_irq(n);
         wait_irq(n);
         wb(MPC_ADR_CMPW, 1'b0, 8'h00, r);
         check("compare readback", r, cw[i]);
         measure(256, hc);
         check("duty high", hc[2], ex[i]);
         check("duty low", hc[5], 256 - ex[i]);
      end
   endtask
   task automatic t_force();
      int n;
      int hc [6];
      logic [7:0] r;
      wb(MPC_ADR_PWMC, 1'b1, 8'h70, r);
      wait_irq(n);
      repeat (2) @(posedge ref_clk);
      measure(250, hc);
      check("forced uvw", hc[0] + hc[1] + hc[2], 750);
      wait_irq(n);
      repeat (2) @(posedge ref_clk);
      measure(250, hc);
      check("force expired", hc[0] + hc[1], 0);
      wb(MPC_ADR_PWMC, 1'b0, 8'h00, r);
      check("force cleared", r, 8'h00);
   endtask
   task automatic t_chop();
      int n;
      int hc [6];
      logic [7:0] r;
      for (int m = 0; m < 4; m++) begin
         wb(MPC_ADR_CCC, 1'b1, 8'(m * 8 + 7), r);
         wb(MPC_ADR_PWMC, 1'b1, 8'h10, r);
         wait_irq(n);
         repeat (2) @(posedge ref_clk);
         measure(100, hc);
         check("chop high", hc[2], (m >= 2) ? 50 : 100);
         check("chop low", hc[3], (m % 2 == 1) ? 50 : 100);
         check("forced low off", hc[5], 0);
      end
   endtask
   // Center-aligned counting: one repetition step is half of the up-down period
   task automatic t_center();
      int n;
      logic [7:0] r;
      wb(MPC_ADR_PWMC, 1'b1, 8'h08, r);
      wait_irq(n);
      wait_irq(n);
      check("center half period", n, int'(MPC_CNT_TOP));
      wb(MPC_ADR_REP, 1'b1, 8'h01, r);
      wait_irq(n);
      wait_irq(n);
      check("center two halves", n, 2 * int'(MPC_CNT_TOP));
   endtask
   // ==========================================================================
   // Main sequence and watchdog
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_status();
      t_pacing();
      t_duty();
      t_force();
      t_chop();
      t_center();
      check("bridge short", leg_short, 1'b0);
      report_and_stop();
   end
   // Whole run needs about 15000 cycles; give it ample margin
   initial begin
      repeat (40000) @(posedge ref_clk);
      err_total++;
      report_and_stop();
   end
endmodule
